// ==== hdl/sdf_params.svh ====
// Offsets, field positions, reset values and decode constants
`ifndef SDF_PARAMS_SVH
`define SDF_PARAMS_SVH
`define SDF_CFG_OFS 8'h93
`define SDF_FUNC_SOCK 1'b0
`define SDF_FUNC_FIFO 1'b1
`define SDF_SOCK_RST 8'h60
`define SDF_FIFO_RST 8'h00
`define SDF_SOCK_FIXED 8'h60
`define SDF_SOCK_WMASK 8'h06
`define SDF_FIFO_WMASK 8'h0f
`define SDF_MODE_LSB 1
`define SDF_MODE_MSB 2
`define SDF_F5V_BIT 6
`define SDF_F3V_BIT 5
`define SDF_WIN_SEL_BIT 11
`define SDF_IDX_LAST 8'h37
`define SDF_IO_INDEX 2'h0
`define SDF_IO_DATA 2'h1
`define SDF_CARD_WORDS 56
`endif

// ==== hdl/sdf_pkg.sv ====
// Types shared by the socket control and FIFO depth block
package sdf_pkg;
  typedef enum logic [1:0] {
    SDF_SP_CFG = 2'h0,
    SDF_SP_IO = 2'h1,
    SDF_SP_MEM = 2'h2,
    SDF_SP_NONE = 2'h3
  } sdf_space_t;
  typedef enum logic [1:0] {
    SDF_IRQ_OFF = 2'h0,
    SDF_IRQ_ISA = 2'h1,
    SDF_IRQ_RSV2 = 2'h2,
    SDF_IRQ_RSV3 = 2'h3
  } sdf_irq_mode_t;
  typedef struct packed {
    logic valid;
    sdf_space_t space;
    logic write;
    logic func;
    logic [31:0] addr;
    logic [7:0] wdata;
  } sdf_req_t;
  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] rdata;
  } sdf_rsp_t;
  typedef struct packed {
    logic cb_read;
    logic cb_write;
    logic pci_read;
    logic pci_write;
  } sdf_fifo_t;
endpackage

// ==== hdl/sdf_fifo_limit.sv ====
// Per-direction single data phase limit for memory transfers
`timescale 1ns/100ps
module sdf_fifo_limit
  import sdf_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] ctrl,
  input wire logic [3:0] is_mem,
  output logic [3:0] single
);
  wire [3:0] next_single;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_dir
      // Limit only memory data, never config or IO (see [RL13])
      assign next_single[g] = ctrl[g] & is_mem[g];
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          single[g] <= 1'b0;
        end else begin
          single[g] <= next_single[g];
        end
      end
    end
  endgenerate
endmodule

// ==== hdl/sdf_card_regs.sv ====
// Byte storage for the 56-entry card register file
`timescale 1ns/100ps
`include "sdf_params.svh"
module sdf_card_regs
  import sdf_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:`SDF_CARD_WORDS-1];
  wire in_range;
  assign in_range = ({2'h0, addr} <= `SDF_IDX_LAST);
  assign rdata = in_range ? mem[addr] : 8'h00;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `SDF_CARD_WORDS; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (we && in_range) begin
      mem[addr] <= wdata;
    end
  end
endmodule

// ==== hdl/sdf_socket_ctrl.sv ====
// Socket control and FIFO depth registers with card register access
`timescale 1ns/100ps
`include "sdf_params.svh"
// What this block does
// [RL1] Socket control bits 7,4,3,0 read zero
// [RL2] Force 5V bit fixed at one
// [RL3] Force 3V bit fixed at one
// [RL4] Mode field acts only with PCI interrupt enable
// [RL5] Mode 00 suppresses, 01 selects ISA
// [RL6] Host never writes modes 10b or 11b; if written they are stored and route nothing, as 00
// [RL7] FIFO control upper nibble reads zero
// [RL8] Bit 3 limits CardBus master reads
// [RL9] Bit 2 limits CardBus master writes
// [RL10] Bit 1 limits PCI master reads
// [RL11] Bit 0 limits PCI bus writes
// [RL12] Set bit means single 4-byte phases; reset zero
// [RL13] Limits affect memory data, not config/IO
// [RL14] Card registers reachable in IO or memory
// [RL15] IO access via index/data at legacy base
// [RL16] Memory access in 4 KB socket window
// [RL17] Memory offset is 800h plus index
// [RL18] Index at base, data base+1, no +2/+3
// [RL19] Card control bit 5 gates INTA#/INTB#
// [RL20] Writes to fixed bits are ignored
module sdf_socket_ctrl
  import sdf_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire sdf_req_t REQ,
  input wire sdf_fifo_t XFER_IS_MEM,
  input wire logic [31:2] LEGACY_IO_BASE,
  input wire logic [31:12] SOCKET_MEM_BASE,
  input wire logic PCI_INT_ENABLE,
  input wire logic CARD_IRQ_A,
  input wire logic CARD_IRQ_B,
  output sdf_rsp_t RSP,
  output sdf_fifo_t SINGLE_PHASE,
  output logic FORCE_5V,
  output logic FORCE_3V,
  output logic ISA_IRQ_A,
  output logic ISA_IRQ_B,
  output logic INTA_OUT,
  output logic INTA_OE_N,
  output logic INTB_OUT,
  output logic INTB_OE_N
);

  // Register storage
  logic [7:0] socket_device_control;
  logic [7:0] fifo_depth_control;
  logic [7:0] card_index;

  // Pin synchronisers
  logic irq_a_meta;
  logic irq_a_sync;
  logic irq_b_meta;
  logic irq_b_sync;

  // Card register file port
  wire card_we;
  wire [5:0] card_addr;
  wire [7:0] card_rdata;

  // Decode
  wire is_cfg;
  wire is_io;
  wire is_mem;
  wire cfg_hit;
  wire cfg_sock;
  wire cfg_fifo;
  wire io_hit;
  wire io_index;
  wire io_data;
  wire io_bad;
  wire mem_hit;
  wire mem_card;
  wire [7:0] mem_index;
  wire claim;
  wire [7:0] sock_read;
  wire [7:0] fifo_read;
  wire [7:0] next_rdata;
  wire [7:0] next_sock;
  wire [7:0] next_fifo;
  wire [7:0] next_index;
  wire sock_we;
  wire fifo_we;
  wire index_we;
  sdf_irq_mode_t irq_mode;
  wire mode_live;
  wire route_isa;
  wire next_isa_a;
  wire next_isa_b;
  wire next_inta_oe_n;
  wire next_intb_oe_n;
  sdf_rsp_t next_rsp;

  function automatic logic [7:0] sdf_merge(input logic [7:0] old_val,
                                           input logic [7:0] new_val,
                                           input logic [7:0] wmask,
                                           input logic [7:0] fixed);
    sdf_merge = ((old_val & ~wmask) | (new_val & wmask)) & wmask | fixed;
  endfunction

  // Space and offset decode
  assign is_cfg = REQ.valid && (REQ.space == SDF_SP_CFG);
  assign is_io = REQ.valid && (REQ.space == SDF_SP_IO);
  assign is_mem = REQ.valid && (REQ.space == SDF_SP_MEM);

  assign cfg_hit = is_cfg && (REQ.addr[7:0] == `SDF_CFG_OFS);
  assign cfg_sock = cfg_hit && (REQ.func == `SDF_FUNC_SOCK);
  assign cfg_fifo = cfg_hit && (REQ.func == `SDF_FUNC_FIFO);

  // Index/data pair at the legacy IO base (see [RL15])
  assign io_hit = is_io && (REQ.addr[31:2] == LEGACY_IO_BASE);
  assign io_index = io_hit && (REQ.addr[1:0] == `SDF_IO_INDEX);
  assign io_data = io_hit && (REQ.addr[1:0] == `SDF_IO_DATA);
  // Base plus two or three answered as an error (see [RL18])
  assign io_bad = io_hit && !io_index && !io_data;

  // Upper half of the socket window maps the card registers (see [RL16])
  assign mem_hit = is_mem && (REQ.addr[31:12] == SOCKET_MEM_BASE);
  assign mem_card = mem_hit && REQ.addr[`SDF_WIN_SEL_BIT];
  // Window offset 800h plus index (see [RL17])
  assign mem_index = REQ.addr[7:0] & {8{REQ.addr[10:8] == 3'h0}};

  assign claim = cfg_hit || io_hit || mem_hit;

  // Card register file in either space (see [RL14])
  assign card_addr = io_data ? card_index[5:0] : mem_index[5:0];
  assign card_we = REQ.write && ((io_data && (card_index <= `SDF_IDX_LAST)) ||
                   (mem_card && (mem_index <= `SDF_IDX_LAST) &&
                    (REQ.addr[10:8] == 3'h0)));

  // Read views with fixed and reserved bits forced (see [RL1] [RL2] [RL3] [RL7])
  assign sock_read = (socket_device_control & `SDF_SOCK_WMASK) | `SDF_SOCK_FIXED;
  assign fifo_read = fifo_depth_control & `SDF_FIFO_WMASK;

  assign next_rdata = cfg_sock ? sock_read :
                      cfg_fifo ? fifo_read :
                      io_index ? card_index :
                      (io_data && card_index <= `SDF_IDX_LAST) ? card_rdata :
                      (mem_card && REQ.addr[10:8] == 3'h0 &&
                       mem_index <= `SDF_IDX_LAST) ? card_rdata :
                      8'h00;

  // Write strobes and merged values
  assign sock_we = cfg_sock && REQ.write;
  assign fifo_we = cfg_fifo && REQ.write;
  assign index_we = io_index && REQ.write;
  // Only writable fields change on a write (see [RL20])
  assign next_sock = sock_we ? sdf_merge(socket_device_control, REQ.wdata,
                                         `SDF_SOCK_WMASK, `SDF_SOCK_FIXED)
                             : socket_device_control;
  assign next_fifo = fifo_we ? sdf_merge(fifo_depth_control, REQ.wdata,
                                         `SDF_FIFO_WMASK, 8'h00)
                             : fifo_depth_control;
  assign next_index = index_we ? REQ.wdata : card_index;

  assign next_rsp.valid = claim;
  assign next_rsp.err = io_bad;
  assign next_rsp.rdata = (claim && !REQ.write && !io_bad) ? next_rdata : 8'h00;

  // Interrupt mode decode
  assign irq_mode = sdf_irq_mode_t'(socket_device_control[`SDF_MODE_MSB:`SDF_MODE_LSB]);
  // Mode is honoured only while PCI interrupts are enabled (see [RL4] [RL19])
  assign mode_live = PCI_INT_ENABLE;
  // 00 generates nothing, 01 routes ISA style; reserved codes act as 00
  assign route_isa = mode_live && (irq_mode == SDF_IRQ_ISA); // see [RL5] [RL6]
  assign next_isa_a = route_isa && irq_a_sync;
  assign next_isa_b = route_isa && irq_b_sync;
  // Open-drain PCI lines pulled low only when enabled (see [RL19])
  assign next_inta_oe_n = !(route_isa && irq_a_sync);
  assign next_intb_oe_n = !(route_isa && irq_b_sync);

  // Register updates
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      socket_device_control <= `SDF_SOCK_RST;
      fifo_depth_control <= `SDF_FIFO_RST; // see [RL12]
      card_index <= 8'h00;
    end else begin
      socket_device_control <= next_sock;
      fifo_depth_control <= next_fifo;
      card_index <= next_index;
    end
  end

  // Two-stage synchronisers for the card interrupt pins
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      irq_a_meta <= 1'b0;
      irq_a_sync <= 1'b0;
      irq_b_meta <= 1'b0;
      irq_b_sync <= 1'b0;
    end else begin
      irq_a_meta <= CARD_IRQ_A;
      irq_a_sync <= irq_a_meta;
      irq_b_meta <= CARD_IRQ_B;
      irq_b_sync <= irq_b_meta;
    end
  end

  // Answer register
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      RSP <= '0;
    end else begin
      RSP <= next_rsp;
    end
  end

  // Supply force outputs follow the fixed bits (see [RL2] [RL3])
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      FORCE_5V <= 1'b1;
      FORCE_3V <= 1'b1;
    end else begin
      FORCE_5V <= sock_read[`SDF_F5V_BIT];
      FORCE_3V <= sock_read[`SDF_F3V_BIT];
    end
  end

  // Interrupt outputs
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      ISA_IRQ_A <= 1'b0;
      ISA_IRQ_B <= 1'b0;
      INTA_OUT <= 1'b0;
      INTA_OE_N <= 1'b1;
      INTB_OUT <= 1'b0;
      INTB_OE_N <= 1'b1;
    end else begin
      ISA_IRQ_A <= next_isa_a;
      ISA_IRQ_B <= next_isa_b;
      INTA_OUT <= 1'b0;
      INTA_OE_N <= next_inta_oe_n;
      INTB_OUT <= 1'b0;
      INTB_OE_N <= next_intb_oe_n;
    end
  end

  // Card register storage
  sdf_card_regs u_card_regs (
    .clk(CLOCK),
    .rstn(RESETN),
    .we(card_we),
    .addr(card_addr),
    .wdata(REQ.wdata),
    .rdata(card_rdata)
  );

  // Depth limit per direction (see [RL8] [RL9] [RL10] [RL11] [RL12] [RL13])
  sdf_fifo_limit u_fifo_limit (
    .clk(CLOCK),
    .rstn(RESETN),
    .ctrl(fifo_depth_control[3:0]),
    .is_mem(XFER_IS_MEM),
    .single(SINGLE_PHASE)
  );

endmodule

// ==== testbench/sdf_socket_ctrl_monitor.sv ====
// Assertion checker for the socket control block
`timescale 1ns/100ps
module sdf_socket_ctrl_monitor
  import sdf_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire sdf_req_t REQ,
  input wire sdf_fifo_t XFER_IS_MEM,
  input wire logic [31:2] LEGACY_IO_BASE,
  input wire logic [31:12] SOCKET_MEM_BASE,
  input wire logic PCI_INT_ENABLE,
  input wire sdf_rsp_t RSP,
  input wire sdf_fifo_t SINGLE_PHASE,
  input wire logic FORCE_5V,
  input wire logic FORCE_3V,
  input wire logic INTA_OUT,
  input wire logic INTA_OE_N,
  input wire logic INTB_OUT,
  input wire logic INTB_OE_N
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  sequence cfg_rd(logic f);
    REQ.valid && REQ.space == SDF_SP_CFG && !REQ.write && REQ.func == f && REQ.addr[7:0] == 8'h93;
  endsequence
  sequence io_high;
    REQ.valid && REQ.space == SDF_SP_IO && REQ.addr[31:2] == LEGACY_IO_BASE && REQ.addr[1];
  endsequence
  sequence mem_hit;
    REQ.valid && REQ.space == SDF_SP_MEM && REQ.addr[31:12] == SOCKET_MEM_BASE;
  endsequence
  sequence int_off;
    (!PCI_INT_ENABLE) [*2];
  endsequence
  AST_SOCK_FIXED: assert property (cfg_rd(1'b0) |=> RSP.valid && (RSP.rdata & 8'hf9) == 8'h60)
    else $error("socket control fixed bits wrong");
  AST_FIFO_HIGH: assert property (cfg_rd(1'b1) |=> RSP.valid && RSP.rdata[7:4] == 4'h0)
    else $error("fifo control upper nibble not zero");
  AST_F5V: assert property (FORCE_5V)
    else $error("force 5V output low");
  AST_F3V: assert property (FORCE_3V)
    else $error("force 3V output low");
  AST_LIMIT: assert property ((SINGLE_PHASE & ~$past(XFER_IS_MEM)) == 4'h0)
    else $error("single phase limit outside memory transfer");
  AST_IO_ERR: assert property (io_high |=> RSP.valid && RSP.err)
    else $error("index port plus two or three not flagged");
  AST_MEM: assert property (mem_hit |=> RSP.valid && !RSP.err)
    else $error("memory window access not answered");
  AST_GATE: assert property (int_off |-> INTA_OE_N && INTB_OE_N)
    else $error("interrupt pulled while disabled");
  AST_OD: assert property (!INTA_OUT && !INTB_OUT)
    else $error("interrupt pin driven high");
endmodule
bind sdf_socket_ctrl sdf_socket_ctrl_monitor u_mon (.CLOCK(CLOCK), .RESETN(RESETN), .REQ(REQ),
  .XFER_IS_MEM(XFER_IS_MEM), .LEGACY_IO_BASE(LEGACY_IO_BASE), .SOCKET_MEM_BASE(SOCKET_MEM_BASE),
  .PCI_INT_ENABLE(PCI_INT_ENABLE), .RSP(RSP), .SINGLE_PHASE(SINGLE_PHASE), .FORCE_5V(FORCE_5V),
  .FORCE_3V(FORCE_3V), .INTA_OUT(INTA_OUT), .INTA_OE_N(INTA_OE_N), .INTB_OUT(INTB_OUT),
  .INTB_OE_N(INTB_OE_N));

// ==== testbench/sdf_host.sv ====
// Host model issuing register and card file accesses
`timescale 1ns/100ps
module sdf_host
  import sdf_pkg::*;
(
  input wire logic CLOCK,
  output sdf_req_t REQ
);
  initial REQ = '0;
  // One request per cycle, launched after a falling edge
  task automatic access(input sdf_space_t sp, input logic wr, input logic fn,
                        input logic [31:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    REQ <= '{valid: 1'b1, space: sp, write: wr, func: fn, addr: a, wdata: d};
  endtask
  // Released bus shows no stale value
  task automatic idle();
    @(negedge CLOCK);
    REQ <= {1'b0, ~REQ[43:0]};
  endtask
endmodule

// ==== testbench/sdf_socket_ctrl_bench.sv ====
// Self-checking bench for the socket control block
`timescale 1ns/100ps
module sdf_socket_ctrl_bench
  import sdf_pkg::*;
;
  localparam logic W = 1'b1;
  localparam logic R = 1'b0;
  localparam logic [31:0] A93 = 32'h0000_0093;
  localparam logic [31:0] IO_A = 32'h0000_03e0;
  localparam logic [31:0] IO_D = 32'h0000_03e1;
  localparam logic [31:0] MEM_A = 32'hc000_0000;
  localparam logic [31:0] MEM_W = 32'hc000_0800;
  logic CLOCK = 1'b0;
  logic RESETN = 1'b0;
  sdf_req_t REQ;
  sdf_fifo_t XFER_IS_MEM = '0;
  logic PCI_INT_ENABLE = 1'b0;
  logic CARD_IRQ_A = 1'b0;
  logic CARD_IRQ_B = 1'b0;
  sdf_rsp_t RSP;
  sdf_fifo_t SINGLE_PHASE;
  logic FORCE_5V, FORCE_3V, ISA_IRQ_A, ISA_IRQ_B, INTA_OUT, INTA_OE_N, INTB_OUT, INTB_OE_N;
  logic [8:0] exp_q[$];
  logic [7:0] v;
  logic [7:0] idx;
  int error_cnt = 0;
  int checks = 0;
  int seed = 78540;
  initial forever #50 CLOCK = ~CLOCK;
  sdf_host u_host (.CLOCK(CLOCK), .REQ(REQ));
  sdf_socket_ctrl u_dut (.CLOCK(CLOCK), .RESETN(RESETN), .REQ(REQ), .XFER_IS_MEM(XFER_IS_MEM),
    .LEGACY_IO_BASE(IO_A[31:2]), .SOCKET_MEM_BASE(MEM_A[31:12]), .PCI_INT_ENABLE(PCI_INT_ENABLE),
    .CARD_IRQ_A(CARD_IRQ_A), .CARD_IRQ_B(CARD_IRQ_B), .RSP(RSP), .SINGLE_PHASE(SINGLE_PHASE),
    .FORCE_5V(FORCE_5V), .FORCE_3V(FORCE_3V), .ISA_IRQ_A(ISA_IRQ_A), .ISA_IRQ_B(ISA_IRQ_B),
    .INTA_OUT(INTA_OUT), .INTA_OE_N(INTA_OE_N), .INTB_OUT(INTB_OUT), .INTB_OE_N(INTB_OE_N));
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Note the expected answer, then issue the request
  task automatic acc(input sdf_space_t sp, input logic wr, input logic fn, input logic [31:0] a,
                     input logic [7:0] d, input logic [8:0] want);
    exp_q.push_back(want);
    u_host.access(sp, wr, fn, a, d);
  endtask
  always @(negedge CLOCK) begin
    if (RSP.valid === 1'b1) begin
      if (exp_q.size() == 0) check({RSP.err, RSP.rdata}, 9'h1ff);
      else check({RSP.err, RSP.rdata}, exp_q.pop_front());
    end
  end
  // Run needs about a hundred cycles
  initial begin
    repeat (5000) @(posedge CLOCK);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge CLOCK);
    @(negedge CLOCK) RESETN = 1'b1;
    acc(SDF_SP_CFG, R, 1'b0, A93, 8'h00, 9'h060);
    acc(SDF_SP_CFG, R, 1'b1, A93, 8'h00, 9'h000);
    acc(SDF_SP_CFG, W, 1'b0, A93, 8'hff, 9'h000);
    acc(SDF_SP_CFG, R, 1'b0, A93, 8'h00, 9'h066);
    acc(SDF_SP_CFG, W, 1'b1, A93, 8'hff, 9'h000);
    acc(SDF_SP_CFG, R, 1'b1, A93, 8'h00, 9'h00f);
    acc(SDF_SP_CFG, W, 1'b0, A93, 8'h00, 9'h000);
    acc(SDF_SP_CFG, R, 1'b0, A93, 8'h00, 9'h060);
    u_host.access(SDF_SP_CFG, R, 1'b0, 32'h0000_0092, 8'h00);
    u_host.access(SDF_SP_NONE, R, 1'b0, A93, 8'h00);
    u_host.idle();
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'hff : 8'($random(seed));
      acc(SDF_SP_CFG, W, 1'b1, A93, v, 9'h000);
      u_host.idle();
      XFER_IS_MEM = sdf_fifo_t'(4'($random(seed)));
      @(negedge CLOCK);
      check(SINGLE_PHASE, {5'h00, v[3:0] & XFER_IS_MEM});
    end
    $display("fifo limit test done");
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed));
      idx = (i == 7) ? 8'h37 : 8'(i * 7);
      acc(SDF_SP_MEM, W, R, MEM_W + 32'(idx), v, 9'h000);
      acc(SDF_SP_IO, W, R, IO_A, idx, 9'h000);
      acc(SDF_SP_IO, R, R, IO_D, 8'h00, {1'b0, v});
      acc(SDF_SP_MEM, R, R, MEM_W + 32'(idx), 8'h00, {1'b0, v});
    end
    acc(SDF_SP_MEM, R, R, MEM_W + 32'h0000_0038, 8'h00, 9'h000);
    acc(SDF_SP_MEM, R, R, MEM_W + 32'h0000_0080, 8'h00, 9'h000);
    acc(SDF_SP_MEM, R, R, MEM_A + 32'h0000_0000, 8'h00, 9'h000);
    acc(SDF_SP_IO, W, R, IO_A, 8'h38, 9'h000);
    acc(SDF_SP_IO, R, R, IO_D, 8'h00, 9'h000);
    acc(SDF_SP_IO, R, R, IO_A + 32'h0000_0002, 8'h00, 9'h100);
    acc(SDF_SP_IO, W, R, IO_A + 32'h0000_0003, 8'h55, 9'h100);
    u_host.idle();
    $display("card file test done");
    acc(SDF_SP_CFG, W, 1'b0, A93, 8'h02, 9'h000);
    acc(SDF_SP_CFG, R, 1'b0, A93, 8'h00, 9'h062);
    u_host.idle();
    CARD_IRQ_A = 1'b1;
    CARD_IRQ_B = 1'b1;
    PCI_INT_ENABLE = 1'b1;
    repeat (4) @(negedge CLOCK);
    check({ISA_IRQ_A, ISA_IRQ_B, INTA_OE_N, INTB_OE_N}, 9'h00c);
    PCI_INT_ENABLE = 1'b0;
    repeat (2) @(negedge CLOCK);
    check({ISA_IRQ_A, ISA_IRQ_B, INTA_OE_N, INTB_OE_N}, 9'h003);
    PCI_INT_ENABLE = 1'b1;
    acc(SDF_SP_CFG, W, 1'b0, A93, 8'h00, 9'h000);
    u_host.idle();
    repeat (4) @(negedge CLOCK);
    check({ISA_IRQ_A, ISA_IRQ_B, INTA_OE_N, INTB_OE_N}, 9'h003);
    $display("interrupt test done");
    check(9'(exp_q.size()), 9'h000);
    report_and_stop();
  end
endmodule
